// >>> rtl/dsps_top.sv
`timescale 1ns/1ps
module dsps_top
  import dsps_pkg::*;
#(
  parameter int unsigned P_CYCLE_LEN = CYCLE_LEN
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_run_hold,
  input  wire logic        i_oscillator_type_select,
  input  wire logic        i_comparator,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic             o_inputs_to_common,
  output logic             o_inputs_to_pins,
  output logic             o_refcap_charge,
  output logic             o_offset_loop,
  output logic             o_positive_node_to_refcap,
  output logic             o_refcap_inverted,
  output logic             o_negative_node_to_common,
  output logic             o_clear_loop,
  output logic [3:0]       o_phase,
  output logic             o_sign_output,
  output logic             o_overrange,
  output logic [11:0]      o_result,
  output logic             o_irq
);

  localparam logic [12:0] CYC_LAST   = 13'(P_CYCLE_LEN - 1);
  localparam logic [12:0] INT_LAST   = 13'(INT_LEN - 1);
  localparam logic [12:0] DEINT_LAST = 13'(DEINT_FULL - 1);
  localparam logic [12:0] CLR_N_LAST = 13'(CLEAR_NORMAL - 1);
  localparam logic [12:0] CLR_O_LAST = 13'(CLEAR_OVR - 1);
  localparam logic [5:0]  DIV_LAST   = 6'(OSC_DIV - 1);

  dsps_phase_t phase_q;
  dsps_phase_t phase_d;
  logic [5:0]  div_q;
  logic [12:0] cyc_q;
  logic [12:0] ph_cnt_q;
  logic        sign_q;
  logic        ovr_q;
  logic [11:0] result_q;
  logic        ctrl_run_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // internal clock tick: divided by 58 for crystal, direct for rc
  wire tick = i_oscillator_type_select | (div_q == DIV_LAST);
  wire run_en = i_run_hold & ctrl_run_q;

  wire int_end   = tick & (phase_q == SIGNAL_INTEGRATE) & (ph_cnt_q == INT_LAST);
  wire crossing  = (i_comparator != sign_q);
  wire de_active = tick & (phase_q == REFERENCE_DEINTEGRATE);
  wire de_cross  = de_active & crossing;
  wire de_full   = de_active & ~crossing & (ph_cnt_q == DEINT_LAST);
  wire de_end    = de_cross | de_full;
  wire [12:0] clr_last = ovr_q ? CLR_O_LAST : CLR_N_LAST;
  wire clr_end   = tick & (phase_q == INTEGRATOR_CLEAR) & (ph_cnt_q == clr_last);
  wire null_end  = tick & (phase_q == OFFSET_NULL) & (cyc_q == CYC_LAST) & run_en;

  always_comb
  begin
    phase_d = phase_q;
    case (phase_q)
      OFFSET_NULL:           if (null_end) phase_d = SIGNAL_INTEGRATE;
      SIGNAL_INTEGRATE:      if (int_end)  phase_d = REFERENCE_DEINTEGRATE;
      REFERENCE_DEINTEGRATE: if (de_end)   phase_d = INTEGRATOR_CLEAR;
      INTEGRATOR_CLEAR:      if (clr_end)  phase_d = OFFSET_NULL;
      default:                             phase_d = OFFSET_NULL;
    endcase
  end

  wire sign_d = int_end ? i_comparator : sign_q;
  wire phase_chg = (phase_d != phase_q);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      div_q <= 6'h00;
    else if (tick)
      div_q <= 6'h00;
    else
      div_q <= div_q + 6'h01;
  end

  // cycle counter restarts with integration; holds at the end while nulling
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cyc_q <= CYC_LAST;
    else if (null_end)
      cyc_q <= 13'h0000;
    else if (tick && cyc_q != CYC_LAST)
      cyc_q <= cyc_q + 13'h0001;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ph_cnt_q <= 13'h0000;
    else if (phase_chg)
      ph_cnt_q <= 13'h0000;
    else if (tick)
      ph_cnt_q <= ph_cnt_q + 13'h0001;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      phase_q  <= OFFSET_NULL;
      sign_q   <= 1'b0;
      ovr_q    <= 1'b0;
      result_q <= 12'h000;
    end
    else
    begin
      phase_q <= phase_d;
      sign_q  <= sign_d;
      if (de_end)
      begin
        ovr_q    <= de_full;
        result_q <= de_full ? 12'hFFF : ph_cnt_q[11:0];
      end
    end
  end

  // analog switch settings follow the next phase so they change with it
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_inputs_to_common        <= 1'b1;
      o_inputs_to_pins          <= 1'b0;
      o_refcap_charge           <= 1'b1;
      o_offset_loop             <= 1'b1;
      o_positive_node_to_refcap <= 1'b0;
      o_refcap_inverted         <= 1'b0;
      o_negative_node_to_common <= 1'b0;
      o_clear_loop              <= 1'b0;
      o_phase                   <= 4'(OFFSET_NULL);
      o_sign_output             <= 1'b0;
      o_overrange               <= 1'b0;
      o_result                  <= 12'h000;
    end
    else
    begin
      o_inputs_to_common        <= (phase_d == OFFSET_NULL);
      o_offset_loop             <= (phase_d == OFFSET_NULL);
      o_inputs_to_pins          <= (phase_d == SIGNAL_INTEGRATE);
      o_refcap_charge           <= (phase_d == OFFSET_NULL) |
                                   (phase_d == INTEGRATOR_CLEAR);
      o_positive_node_to_refcap <= (phase_d == REFERENCE_DEINTEGRATE);
      o_refcap_inverted         <= (phase_d == REFERENCE_DEINTEGRATE) & sign_d;
      o_negative_node_to_common <= (phase_d == REFERENCE_DEINTEGRATE) |
                                   (phase_d == INTEGRATOR_CLEAR);
      o_clear_loop              <= (phase_d == INTEGRATOR_CLEAR);
      o_phase                   <= 4'(phase_d);
      o_sign_output             <= sign_d;
      if (de_end)
      begin
        o_overrange <= de_full;
        o_result    <= de_full ? 12'hFFF : ph_cnt_q[11:0];
      end
    end
  end

  // register bus: write address and data taken independently
  wire wr_go   = aw_held_q & w_held_q & ~o_s_axi_bvalid;
  wire wr_ctrl = wr_go & (awaddr_q == ADDR_CTRL) & wstrb_q[0];
  wire wr_stat = wr_go & (awaddr_q == ADDR_IRQ_STAT) & wstrb_q[0];
  wire wr_mask = wr_go & (awaddr_q == ADDR_IRQ_MASK) & wstrb_q[0];
  wire wr_ok   = (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_STATUS) |
                 (awaddr_q == ADDR_IRQ_STAT) | (awaddr_q == ADDR_IRQ_MASK);
  wire rd_go   = i_s_axi_arvalid & o_s_axi_arready;
  wire [1:0] irq_evt = {de_full, de_end};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= {i_s_axi_awaddr[31:2], 2'b00};
      end
      else if (wr_go)
        aw_held_q <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= i_s_axi_wdata;
        wstrb_q  <= i_s_axi_wstrb;
      end
      else if (wr_go)
        w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      o_s_axi_awready <= ~aw_held_q & ~(i_s_axi_awvalid & o_s_axi_awready);
      o_s_axi_wready  <= ~w_held_q & ~(i_s_axi_wvalid & o_s_axi_wready);
      if (wr_go)
      begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_run_q <= CTRL_RUN_RST;
      irq_mask_q <= IRQ_RST;
      irq_stat_q <= IRQ_RST;
      o_irq      <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_run_q <= wdata_q[0];
      if (wr_mask)
        irq_mask_q <= wdata_q[1:0];
      // a new event wins over a write-one clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~({2{wr_stat}} & wdata_q[1:0])) | irq_evt;
      o_irq      <= |(((irq_stat_q & ~({2{wr_stat}} & wdata_q[1:0])) | irq_evt) & irq_mask_q);
    end
  end

  wire [31:0] status_word = {12'h000, o_phase, 2'b00, ovr_q, sign_q, result_q};
  wire [31:0] rd_data =
    (i_s_axi_araddr[31:2] == ADDR_CTRL[31:2])     ? {31'h0000_0000, ctrl_run_q} :
    (i_s_axi_araddr[31:2] == ADDR_STATUS[31:2])   ? status_word :
    (i_s_axi_araddr[31:2] == ADDR_IRQ_STAT[31:2]) ? {30'h0000_0000, irq_stat_q} :
    (i_s_axi_araddr[31:2] == ADDR_IRQ_MASK[31:2]) ? {30'h0000_0000, irq_mask_q} :
                                                    32'h0000_0000;
  wire rd_ok = (i_s_axi_araddr[31:4] == 28'h000_0000);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= ~o_s_axi_rvalid & ~rd_go;
      if (rd_go)
      begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= rd_data;
        o_s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (i_s_axi_rready)
        o_s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> rtl/dsps_pkg.sv
package dsps_pkg;

  typedef enum logic [3:0]
  {
    OFFSET_NULL           = 4'b0001,
    SIGNAL_INTEGRATE      = 4'b0010,
    REFERENCE_DEINTEGRATE = 4'b0100,
    INTEGRATOR_CLEAR      = 4'b1000
  } dsps_phase_t;

  localparam int unsigned CYCLE_LEN     = 8192;
  localparam int unsigned INT_LEN       = 2048;
  localparam int unsigned DEINT_FULL    = 4096;
  localparam int unsigned CLEAR_NORMAL  = 32;
  localparam int unsigned CLEAR_OVR     = 1552;
  localparam int unsigned OSC_DIV       = 58;

  localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000C;

  localparam int unsigned ST_SIGN_BIT   = 12;
  localparam int unsigned ST_OVR_BIT    = 13;
  localparam int unsigned ST_PHASE_LSB  = 16;
  localparam int unsigned IRQ_DONE_BIT  = 0;
  localparam int unsigned IRQ_OVR_BIT   = 1;

  localparam logic        CTRL_RUN_RST  = 1'b1;
  localparam logic [1:0]  IRQ_RST       = 2'b00;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

endpackage

// >>> verif/dsps_chk.sv
`timescale 1ns/1ps
module dsps_chk
  import dsps_pkg::*;
#(
  parameter int unsigned P_CYCLE_LEN = CYCLE_LEN
)
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_run_hold,
  input wire logic       o_inputs_to_common,
  input wire logic       o_inputs_to_pins,
  input wire logic       o_refcap_charge,
  input wire logic       o_offset_loop,
  input wire logic       o_positive_node_to_refcap,
  input wire logic       o_refcap_inverted,
  input wire logic       o_negative_node_to_common,
  input wire logic       o_clear_loop,
  input wire logic [3:0] o_phase,
  input wire logic       o_sign_output,
  input wire logic       o_overrange
);
  logic [11:0] int_cnt_q;
  logic [10:0] clr_cnt_q;
  logic [15:0] cyc_cnt_q;
  logic        was_int_q;
  logic        start_q;
  logic        held_q;
  wire         int_start = (o_phase == 4'h2) && !was_int_q;
  wire  [3:0]  rot = {o_phase[2:0], o_phase[3]};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      int_cnt_q <= '0;
      clr_cnt_q <= '0;
      cyc_cnt_q <= '0;
      was_int_q <= 1'h0;
      start_q   <= 1'h0;
      held_q    <= 1'h0;
    end
    else
    begin
      int_cnt_q <= (o_phase == 4'h2) ? int_cnt_q + 12'h001 : 12'h000;
      clr_cnt_q <= (o_phase == 4'h8) ? clr_cnt_q + 11'h001 : 11'h000;
      cyc_cnt_q <= int_start ? 16'h0001 : cyc_cnt_q + 16'h0001;
      was_int_q <= (o_phase == 4'h2);
      start_q   <= start_q | int_start;
      held_q    <= int_start ? !i_run_hold : (held_q | !i_run_hold);
    end
  end
  phase_onehot_a:
    assert property ($onehot(o_phase)) else $error("phase not one-hot");
  phase_order_a:
    assert property ($changed(o_phase) |-> o_phase == $past(rot)) else $error("phase order");
  null_switch_a:
    assert property (o_phase == 4'h1 |-> o_inputs_to_common && o_refcap_charge && o_offset_loop
      && !o_inputs_to_pins) else $error("null switches wrong");
  int_switch_a:
    assert property (o_phase == 4'h2 |-> o_inputs_to_pins && !o_inputs_to_common
      && !o_offset_loop && !o_clear_loop) else $error("integrate switches wrong");
  deint_switch_a:
    assert property (o_phase == 4'h4 |-> o_positive_node_to_refcap && o_negative_node_to_common
      && o_refcap_inverted == o_sign_output) else $error("deintegrate switches wrong");
  clear_switch_a:
    assert property (o_phase == 4'h8 |-> o_clear_loop && o_negative_node_to_common
      && o_refcap_charge && !o_positive_node_to_refcap) else $error("clear switches wrong");
  int_length_a:
    assert property ($fell(o_phase == 4'h2) |-> int_cnt_q == 12'h800) else $error("integrate length");
  clear_length_a:
    assert property ($fell(o_phase == 4'h8) |-> clr_cnt_q == (o_overrange ? 11'h610 : 11'h020))
      else $error("clear length");
  cycle_length_a:
    assert property (int_start && start_q && !held_q |-> cyc_cnt_q == P_CYCLE_LEN)
      else $error("cycle length");
  hold_null_a:
    assert property (o_phase == 4'h1 && !i_run_hold |=> o_phase == 4'h1) else $error("hold left null");
  cover property (o_phase == 4'h4 && o_refcap_inverted);
  cover property ($rose(o_overrange));
  cover property (o_phase == 4'h1 && !i_run_hold);
endmodule

bind dsps_top dsps_chk #(.P_CYCLE_LEN(P_CYCLE_LEN)) dsps_chk_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_run_hold(i_run_hold),
  .o_inputs_to_common(o_inputs_to_common), .o_inputs_to_pins(o_inputs_to_pins),
  .o_refcap_charge(o_refcap_charge), .o_offset_loop(o_offset_loop),
  .o_positive_node_to_refcap(o_positive_node_to_refcap), .o_refcap_inverted(o_refcap_inverted),
  .o_negative_node_to_common(o_negative_node_to_common), .o_clear_loop(o_clear_loop),
  .o_phase(o_phase), .o_sign_output(o_sign_output), .o_overrange(o_overrange)
);

// >>> verif/dsps_analog.sv
`timescale 1ns/1ps
module dsps_analog
(
  input  wire logic        i_clk,
  input  wire logic [3:0]  i_phase,
  input  wire logic        i_pos,
  input  wire logic [12:0] i_mag,
  output logic             o_comparator
);
  logic [12:0] cnt_q;
  initial o_comparator = 1'h0;
  // ramp returns through zero after i_mag ticks, never if beyond full scale
  always @(posedge i_clk)
  begin
    if (i_phase != 4'h4)
    begin
      cnt_q        <= '0;
      o_comparator <= i_pos;
    end
    else
    begin
      cnt_q <= cnt_q + 13'h0001;
      if (cnt_q == i_mag) o_comparator <= ~i_pos;
    end
  end
endmodule

// >>> verif/dual_slope_phase_sequencer_test.sv
`timescale 1ns/1ps
module dual_slope_phase_sequencer_test
  import dsps_pkg::*;
;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        run = 1'h1;
  logic        pos = 1'h1;
  logic        oscillator_type_select = 1'h1;
  logic [12:0] mag = 13'h03E8;
  logic [31:0] aw_addr = '0, w_data = '0, ar_addr = '0, d;
  logic        aw_val = 1'h0, w_val = 1'h0, b_rdy = 1'h0, ar_val = 1'h0, r_rdy = 1'h0;
  logic        aw_rdy, w_rdy, b_val, ar_rdy, r_val, cmp, sign, ovr, irq;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_data;
  logic [3:0]  phase;
  logic [11:0] res;
  int          err_total = 0, cmp_count = 0;
  initial
  begin
    forever #5 clk = ~clk;
  end
  dsps_top dsps_top_inst (.i_clk(clk), .i_rstn(rstn), .i_run_hold(run),
    .i_oscillator_type_select(oscillator_type_select), .i_comparator(cmp), .i_s_axi_awaddr(aw_addr),
    .i_s_axi_awvalid(aw_val), .o_s_axi_awready(aw_rdy), .i_s_axi_wdata(w_data),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(w_val), .o_s_axi_wready(w_rdy), .o_s_axi_bresp(b_resp),
    .o_s_axi_bvalid(b_val), .i_s_axi_bready(b_rdy), .i_s_axi_araddr(ar_addr),
    .i_s_axi_arvalid(ar_val), .o_s_axi_arready(ar_rdy), .o_s_axi_rdata(r_data),
    .o_s_axi_rresp(r_resp), .o_s_axi_rvalid(r_val), .i_s_axi_rready(r_rdy),
    .o_inputs_to_common(), .o_inputs_to_pins(), .o_refcap_charge(), .o_offset_loop(),
    .o_positive_node_to_refcap(), .o_refcap_inverted(), .o_negative_node_to_common(),
    .o_clear_loop(), .o_phase(phase), .o_sign_output(sign), .o_overrange(ovr), .o_result(res),
    .o_irq(irq));
  dsps_analog dsps_analog_inst (.i_clk(clk), .i_phase(phase), .i_pos(pos), .i_mag(mag),
    .o_comparator(cmp));
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_in(input string nm, input logic [31:0] lo, hi, got);
    cmp_count++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      err_total++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, got);
      if (nm == "timeout") end_sim();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    chk_in(nm, exp, exp, got);
  endtask
  task automatic wait_ph(input logic [3:0] p);
    int n;
    n = 0;
    while (phase !== p && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20000) chk("timeout", 32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic wr(input logic [31:0] a, dt, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    aw_addr <= a;
    w_data  <= dt;
    aw_val  <= 1'h1;
    w_val   <= 1'h1;
    b_rdy   <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (aw_rdy === 1'h1) aw_val <= 1'h0;
      if (w_rdy === 1'h1) w_val <= 1'h0;
    end while (b_val !== 1'h1 && n < 100);
    b_rdy <= 1'h0;
    if (n == 100) chk("timeout", 32'h0000_0000, 32'h0000_0001);
    chk("bresp", {30'h0, er}, {30'h0, b_resp});
  endtask
  task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] dt);
    int n;
    n = 0;
    @(posedge clk);
    ar_addr <= a;
    ar_val  <= 1'h1;
    r_rdy   <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (ar_rdy === 1'h1) ar_val <= 1'h0;
    end while (r_val !== 1'h1 && n < 100);
    r_rdy <= 1'h0;
    dt = r_data;
    if (n == 100) chk("timeout", 32'h0000_0000, 32'h0000_0001);
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
  endtask
  task automatic conv(input logic p, input logic [12:0] m);
    logic o;
    o = (m > 13'h0FFF);
    pos <= p;
    mag <= m;
    wait_ph(4'h4);
    wait_ph(4'h1);
    chk("sign", {31'h0, p}, {31'h0, sign});
    chk("overrange", {31'h0, o}, {31'h0, ovr});
    if (o) chk("result", 32'h0000_0FFF, {20'h0, res});
    else chk_in("result", {19'h0, m}, {19'h0, m} + 32'h3, {20'h0, res});
    rd(ADDR_STATUS, RESP_OKAY, d);
    chk("status", {24'h0, 4'h1, 2'h0, o, p}, {24'h0, d[19:12]});
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    chk("reset phase", 32'h0000_0001, {28'h0, phase});
    rstn <= 1'h1;
    repeat (2) @(posedge clk);
    rd(ADDR_CTRL, RESP_OKAY, d);
    chk("ctrl", 32'h0000_0001, d);
    rd(ADDR_IRQ_MASK, RESP_OKAY, d);
    chk("irq mask", 32'h0000_0000, d);
    rd(32'h0000_0010, RESP_SLVERR, d);
    chk("unmapped read", 32'h0000_0000, d);
    wr(32'h0000_0020, 32'hFFFF_FFFF, RESP_SLVERR);
    conv(1'h1, 13'h03E8);
    chk("masked irq", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_0003, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    conv(1'h0, 13'h012C);
    conv(1'h1, 13'h1388);
    rd(ADDR_IRQ_STAT, RESP_OKAY, d);
    chk("irq status", 32'h0000_0003, d);
    wr(ADDR_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
    conv(1'h0, 13'h0002);
    run <= 1'h0;
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (9000) @(posedge clk);
    chk("held phase", 32'h0000_0001, {28'h0, phase});
    rd(ADDR_CTRL, RESP_OKAY, d);
    chk("ctrl off", 32'h0000_0000, d);
    run <= 1'h1;
    repeat (20) @(posedge clk);
    chk("ctrl held phase", 32'h0000_0001, {28'h0, phase});
    run <= 1'h0;
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    // divided tick: null ends only on the 58th clock
    oscillator_type_select <= 1'h0;
    run     <= 1'h1;
    repeat (58) @(posedge clk);
    chk("divided tick", 32'h0000_0001, {28'h0, phase});
    oscillator_type_select <= 1'h1;
    @(posedge clk);
    chk("divided start", 32'h0000_0002, {28'h0, phase});
    conv(1'h1, 13'h0FA0);
    conv(1'h0, 13'h0010);
    end_sim();
  end
endmodule
